// ==== slp_pkg.sv ====
// Constants for the staged parameter update block
package slp_pkg;
    localparam int SLP_DATA_W = 32;
    localparam int SLP_ADDR_W = 16;
    localparam int SLP_SLOTS = 5;
    localparam int SLP_CNT_W = 16;
    // Parameter memory locations of the staging area
    localparam logic [15:0] SLP_ADDR_MODULO = 16'h0000;
    localparam logic [15:0] SLP_ADDR_DATA1 = 16'h0001;
    localparam logic [15:0] SLP_ADDR_DATA5 = 16'h0005;
    localparam logic [15:0] SLP_ADDR_TARGET = 16'h0006;
    localparam logic [15:0] SLP_ADDR_COUNT = 16'h0007;
    localparam logic [2:0] SLP_MAX_WORDS = 3'h5;
    localparam logic [31:0] SLP_MODULO_RST = 32'h00000000;
    // Init code depth reserved at the bottom of program memory
    localparam int SLP_INIT_PROG_WORDS = 36;
    localparam int SLP_PROG_W = 16;
    localparam logic [15:0] SLP_INIT_PROG_BASE = 16'h0000;
    localparam logic [15:0] SLP_INIT_PROG_LAST = 16'h0023;
    typedef enum logic [2:0] {
        SLP_IDLE = 3'b001,
        SLP_WAIT = 3'b010,
        SLP_COPY = 3'b100
    } slp_state_t;
endpackage

// ==== slp_stage_regs.sv ====
// Staging slots, modulo size, target and count storage
`timescale 1ns/1ps
`default_nettype none
module slp_stage_regs
    import slp_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic wr_en_in,
    input wire logic [SLP_ADDR_W-1:0] wr_addr_in,
    input wire logic [SLP_DATA_W-1:0] wr_data_in,
    input wire logic [2:0] rd_slot_in,
    output logic [SLP_DATA_W-1:0] rd_data_out,
    output logic [SLP_DATA_W-1:0] modulo_out,
    output logic [SLP_ADDR_W-1:0] target_out,
    output logic [SLP_CNT_W-1:0] count_out,
    output logic count_wr_out
);
    logic [SLP_DATA_W-1:0] slot [SLP_SLOTS];
    logic [SLP_DATA_W-1:0] modulo;
    logic [SLP_ADDR_W-1:0] target;
    logic [SLP_CNT_W-1:0] count;
    wire logic hit_modulo = wr_en_in && (wr_addr_in == SLP_ADDR_MODULO);
    wire logic hit_target = wr_en_in && (wr_addr_in == SLP_ADDR_TARGET);
    wire logic hit_count = wr_en_in && (wr_addr_in == SLP_ADDR_COUNT);

    genvar gi;
    generate
        for (gi = 0; gi < SLP_SLOTS; gi++) begin : g_slot
            wire logic hit = wr_en_in &&
                (wr_addr_in == SLP_ADDR_DATA1 + 16'(gi));
            always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
                if (!rst_n_in) slot[gi] <= '0;
                else if (hit) slot[gi] <= wr_data_in;
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            modulo <= SLP_MODULO_RST;
            target <= '0;
            count <= '0;
            count_wr_out <= 1'b0;
        end else begin
            if (hit_modulo) modulo <= wr_data_in;
            if (hit_target) target <= wr_data_in[SLP_ADDR_W-1:0];
            if (hit_count) count <= wr_data_in[SLP_CNT_W-1:0];
            count_wr_out <= hit_count;
        end
    end

    assign rd_data_out = (rd_slot_in < SLP_MAX_WORDS) ?
        slot[rd_slot_in] : '0;
    assign modulo_out = modulo;
    assign target_out = target;
    assign count_out = count;
endmodule // slp_stage_regs
`default_nettype wire

// ==== slp_safeload.sv ====
// Frame-synchronous staged parameter update engine
`timescale 1ns/1ps
`default_nettype none
// Function
// - Location zero holds modulo memory size
// - Locations one to five are staging slots
// - Location six holds target address minus one
// - Destination address increments per staged word
// - Location seven holds the word count
// - Count write arms copy at next frame
// - Pending transfer serviced once per frame
// - Init code occupies lowest program memory
module slp_safeload
    import slp_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Host control port writes into locations 0x0000..0x0007
    input wire logic host_wr_in,
    input wire logic [SLP_ADDR_W-1:0] host_addr_in,
    input wire logic [SLP_DATA_W-1:0] host_data_in,
    // One-cycle pulse at each audio frame boundary
    input wire logic frame_start_in,
    output logic pm_wr_out,
    output logic [SLP_ADDR_W-1:0] pm_addr_out,
    output logic [SLP_DATA_W-1:0] pm_data_out,
    output logic [SLP_DATA_W-1:0] modulo_size_out,
    output logic [SLP_PROG_W-1:0] init_prog_last_out,
    output logic pending_out,
    output logic busy_out,
    output logic frame_hold_out
);
    slp_state_t state;
    slp_state_t next_state;

    // Copy engine registers
    logic [2:0] idx;
    logic [2:0] next_idx;
    logic [2:0] words;
    logic [2:0] next_words;
    logic [SLP_ADDR_W-1:0] base;
    logic [SLP_ADDR_W-1:0] next_base;
    logic rearm;
    logic next_rearm;

    // Values seen through the staging store
    logic [SLP_DATA_W-1:0] slot_data;
    logic [SLP_ADDR_W-1:0] target;
    logic [SLP_CNT_W-1:0] count;
    logic arm;

    // Parameter memory write port, next values
    logic next_pm_wr;
    logic [SLP_ADDR_W-1:0] next_pm_addr;
    logic [SLP_DATA_W-1:0] next_pm_data;

    function automatic logic [2:0] clip_count(input logic [15:0] c);
        if (c > 16'(SLP_MAX_WORDS)) begin
            clip_count = SLP_MAX_WORDS;
        end else begin
            clip_count = c[2:0];
        end
    endfunction

    slp_stage_regs u_regs (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(host_wr_in),
        .wr_addr_in(host_addr_in),
        .wr_data_in(host_data_in),
        .rd_slot_in(idx),
        .rd_data_out(slot_data),
        .modulo_out(modulo_size_out),
        .target_out(target),
        .count_out(count),
        .count_wr_out(arm)
    );

    // Clipped request length as seen right now
    wire logic [2:0] req_words = clip_count(count);
    wire logic zero_count = (req_words == 3'h0);
    wire logic in_idle = (state == SLP_IDLE);
    wire logic in_wait = (state == SLP_WAIT);
    wire logic in_copy = (state == SLP_COPY);
    wire logic last_word = (idx + 3'h1 >= words);
    // A fresh arm in the frame cycle defers the copy by one frame
    wire logic start_copy = in_wait && frame_start_in && !arm;
    wire logic copy_step = in_copy && !last_word;
    // Arm is a one-cycle pulse; mid-copy it is kept in rearm
    wire logic late_arm = arm || rearm;

    always_comb begin
        next_state = state;
        case (state)
            SLP_IDLE: begin
                if (arm) begin
                    next_state = SLP_WAIT;
                end
            end
            SLP_WAIT: begin
                if (start_copy) begin
                    if (zero_count) begin
                        next_state = SLP_IDLE;
                    end else begin
                        next_state = SLP_COPY;
                    end
                end
            end
            SLP_COPY: begin
                if (last_word) begin
                    if (late_arm) begin
                        next_state = SLP_WAIT;
                    end else begin
                        next_state = SLP_IDLE;
                    end
                end
            end
            default: begin
                next_state = SLP_IDLE;
            end
        endcase
    end

    always_comb begin
        next_rearm = rearm;
        if (!in_copy) begin
            next_rearm = 1'b0;
        end else if (arm) begin
            next_rearm = 1'b1;
        end
    end

    // Latch length and base at the boundary so host writes can't skew it
    always_comb begin
        next_idx = idx;
        next_words = words;
        next_base = base;
        if (start_copy) begin
            next_idx = 3'h0;
            next_words = req_words;
            next_base = target + 16'h0001;
        end else if (copy_step) begin
            next_idx = idx + 3'h1;
        end
    end

    assign next_pm_wr = in_copy;
    assign next_pm_addr = base + 16'(idx);
    assign next_pm_data = slot_data;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= SLP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rearm <= 1'b0;
        end else begin
            rearm <= next_rearm;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idx <= 3'h0;
        end else begin
            idx <= next_idx;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            words <= 3'h0;
        end else begin
            words <= next_words;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            base <= '0;
        end else begin
            base <= next_base;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pm_wr_out <= 1'b0;
        end else begin
            pm_wr_out <= next_pm_wr;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pm_addr_out <= '0;
        end else begin
            pm_addr_out <= next_pm_addr;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pm_data_out <= '0;
        end else begin
            pm_data_out <= next_pm_data;
        end
    end

    assign pending_out = in_wait;
    assign busy_out = !in_idle;
    // Holds frame processing off parameter reads until the copy lands
    assign frame_hold_out = (state == SLP_COPY) || pm_wr_out;
    assign init_prog_last_out = SLP_INIT_PROG_LAST;
endmodule // slp_safeload
`default_nettype wire

// ==== slp_host_model.sv ====
// Host model for the staged update block
`timescale 1ns/1ps
`default_nettype none
module slp_host_model (
    input wire logic clk_sys_in,
    output logic host_wr_in = '0,
    output logic [15:0] host_addr_in = '0,
    output logic [31:0] host_data_in = '0
);
    task automatic put(logic [15:0] a, logic [31:0] d);
        @(negedge clk_sys_in);
        {host_wr_in, host_addr_in, host_data_in} = {1'b1, a, d};
        @(negedge clk_sys_in);
        {host_wr_in, host_addr_in, host_data_in} = {1'b0, ~a, ~d};
    endtask
    // Count goes last as it arms; callers space calls a frame apart
    task automatic safeload(logic [15:0] t, logic [15:0] n);
        for (int k = 0; k < 8; k++) put(16'(k), k == 7 ? 32'(n) :
            k == 6 ? 32'(t - 16'h1) : 32'ha0000000 + 32'(k));
    endtask
endmodule // slp_host_model
`default_nettype wire

// ==== slp_safeload_properties.sv ====
// Checker for the staged update block
`timescale 1ns/1ps
`default_nettype none
module slp_safeload_chk (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic host_wr_in,
    input wire logic [15:0] host_addr_in,
    input wire logic frame_start_in,
    input wire logic pm_wr_out,
    input wire logic [15:0] pm_addr_out,
    input wire logic pending_out,
    input wire logic frame_hold_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    wire logic cw = host_wr_in && host_addr_in == 16'h7;
    a_arm_wait: assert property (cw && !pending_out && !frame_hold_out
        |-> ##2 pending_out) else $error("arm");
    a_arm_late: assert property (cw && frame_hold_out
        |-> ##[1:7] pending_out) else $error("late arm");
    a_pend_keep: assert property (pending_out && !frame_start_in
        |=> pending_out) else $error("keep");
    a_req_clear: assert property (pending_out && frame_start_in
        && !$past(cw) |=> !pending_out) else $error("clear");
    a_pend_lead: assert property ($rose(pm_wr_out)
        |-> $past(pending_out, 2)) else $error("lead");
    a_frame_lead: assert property ($rose(pm_wr_out)
        |-> $past(frame_start_in, 2)) else $error("frame");
    a_addr_step: assert property (pm_wr_out && $past(pm_wr_out)
        |-> pm_addr_out == $past(pm_addr_out) + 16'h1) else $error("step");
    a_five_max: assert property (pm_wr_out [*5] |=> !pm_wr_out)
        else $error("six");
    a_hold_copy: assert property (pm_wr_out |-> frame_hold_out)
        else $error("hold");
endmodule // slp_safeload_chk
bind slp_safeload slp_safeload_chk u_chk (.*);
`default_nettype wire

// ==== tb_top.sv ====
// Bench for the staged update block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, frame_start_in = 1'b0;
    logic host_wr_in, pm_wr_out, pending_out, busy_out, frame_hold_out;
    logic [15:0] host_addr_in, pm_addr_out, init_prog_last_out;
    logic [31:0] host_data_in, pm_data_out, modulo_size_out;
    int err_total, cmp_count;
    always #25 clk_sys_in = ~clk_sys_in;
    slp_host_model u_host (.*);
    slp_safeload u_dut (.*);
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) err_total++;
        if (g !== e) $display("Error %s exp %h got %h", nm, e, g);
    endtask
    task automatic report_and_stop;
        $display("Compares %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic run(logic [15:0] t, logic [15:0] n);
        int g = 0;
        u_host.safeload(t, n);
        for (int k = 0; k < 14; k++) begin
            frame_start_in = (k == 2) || (k == 9);
            @(negedge clk_sys_in);
            if (pm_wr_out === 1'b1) begin
                chk("addr", 32'(t + 16'(g)), 32'(pm_addr_out));
                chk("data", 32'ha0000001 + g, pm_data_out);
                chk("hold", 1, frame_hold_out);
                g++;
            end
        end
        chk("words", n > 16'h5 ? 5 : 32'(n), g);
        chk("pending", 0, pending_out);
    endtask
    task automatic run_zero;
        int g = 0;
        u_host.safeload(16'h0040, 16'h0);
        @(negedge clk_sys_in);
        chk("pending", 1, pending_out);
        chk("busy", 1, busy_out);
        frame_start_in = 1'b1;
        @(negedge clk_sys_in);
        frame_start_in = 1'b0;
        chk("pending", 0, pending_out);
        for (int k = 0; k < 6; k++) begin
            @(negedge clk_sys_in);
            if (pm_wr_out === 1'b1) g++;
        end
        chk("words", 0, g);
        chk("busy", 0, busy_out);
    endtask
    task automatic run_late;
        int g = 0;
        u_host.safeload(16'h0020, 16'h5);
        @(negedge clk_sys_in);
        frame_start_in = 1'b1;
        @(negedge clk_sys_in);
        frame_start_in = 1'b0;
        u_host.put(16'h0007, 32'h00000002);
        repeat (8) @(negedge clk_sys_in);
        chk("rearm", 1, pending_out);
        frame_start_in = 1'b1;
        @(negedge clk_sys_in);
        frame_start_in = 1'b0;
        for (int k = 0; k < 8; k++) begin
            @(negedge clk_sys_in);
            if (pm_wr_out === 1'b1) begin
                chk("addr", 32'(16'h0020 + 16'(g)), 32'(pm_addr_out));
                chk("data", 32'ha0000001 + g, pm_data_out);
                g++;
            end
        end
        chk("words", 2, g);
        chk("busy", 0, busy_out);
    endtask
    initial begin
        repeat (5) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        chk("prog_last", 32'h00000023, 32'(init_prog_last_out));
        run(16'h000a, 16'h1);
        chk("modulo", 32'ha0000000, modulo_size_out);
        run(16'h00ff, 16'h5);
        run(16'h0100, 16'h9);
        run_zero();
        run_late();
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
